// >>> ethrc_pkg.sv
package ethrc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and time conversion

  localparam int unsigned CLK_PERIOD_NS = 40;  // 25 MHz system clock

  // least time in ns to whole clock cycles, rounded up, never below one
  function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
    int unsigned cyc;
    cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (cyc < 1) ? 1 : cyc;
  endfunction : ns_to_cyc_up

  // width of a counter that must hold the value n
  function automatic int unsigned cnt_width(input int unsigned n);
    return $clog2(n + 1);
  endfunction : cnt_width

  ////////////////////////////////////////////////////////////////////////////
  // timing counts

  localparam int unsigned RSTLOW_NS    = 400;    // widest reset pin glitch ignored
  localparam int unsigned RSTLOW_CYC   = ns_to_cyc_up(RSTLOW_NS);
  localparam int unsigned RSTLOW_W     = cnt_width(RSTLOW_CYC);
  localparam int unsigned PHY_RST_NS   = 10000;  // internal phy reset hold time
  localparam int unsigned PHY_RST_CYC  = ns_to_cyc_up(PHY_RST_NS);
  localparam int unsigned PHY_RST_W    = cnt_width(PHY_RST_CYC);
  localparam int unsigned PHY_WAIT_US  = 50;     // host wait after system reset
  localparam int unsigned PHY_WAIT_CYC = ns_to_cyc_up(PHY_WAIT_US * 1000);

  ////////////////////////////////////////////////////////////////////////////
  // register selection indices

  localparam logic REG_SEL_ETH_CTRL1 = 1'h0;
  localparam logic REG_SEL_PHY_CTRL1 = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // ethernet_control_one fields

  localparam int unsigned ECTL_TX_RST  = 7;
  localparam int unsigned ECTL_RX_RST  = 6;
  localparam int unsigned ECTL_TX_REQ  = 3;
  localparam int unsigned ECTL_RX_EN   = 2;
  localparam logic [7:0]  ECTL_RESET   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // phy_control_one fields

  localparam int unsigned PCTL_SOFT_RST = 15;
  localparam int unsigned PCTL_LOOPBACK = 14;
  localparam int unsigned PCTL_PWR_DOWN = 11;
  localparam int unsigned PCTL_RSVD_HI  = 10;
  localparam int unsigned PCTL_DUPLEX   = 8;
  localparam int unsigned PCTL_RSVD_LO  = 7;
  localparam logic [15:0] PCTL_IMPL     = 16'hcd80;  // implemented bits
  localparam logic [15:0] PCTL_RESET    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // phy reset sequencer states

  typedef enum logic [2:0] {
    PHY_IDLE  = 3'b001,
    PHY_HOLD  = 3'b010,
    PHY_STRAP = 3'b100
  } ethrc_phy_state_e;

endpackage : ethrc_pkg

// >>> ethrc_rst_filter.sv
`timescale 1ns/10ps
`default_nettype none

module ethrc_rst_filter (
  // clock and power-on reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // external reset pin level
  input  wire logic pin_n_i,
  // qualified low level
  output logic      qual_o
);
  import ethrc_pkg::*;

  logic [RSTLOW_W-1:0] low_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // count consecutive low cycles; short glitches never reach the limit
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_cnt_q <= '0;
      qual_o    <= 1'b0;
    end else if (pin_n_i) begin
      low_cnt_q <= '0;
      qual_o    <= 1'b0;  // release follows the pin going high
    end else if (low_cnt_q == RSTLOW_W'(RSTLOW_CYC)) begin
      qual_o    <= 1'b1;  // low held past the qualification width
    end else begin
      low_cnt_q <= low_cnt_q + RSTLOW_W'(1);
    end
  end

endmodule : ethrc_rst_filter

`default_nettype wire

// >>> ethrc_rst_sync.sv
`timescale 1ns/10ps
`default_nettype none

module ethrc_rst_sync (
  // clock and power-on reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // reset request level
  input  wire logic req_i,
  // synchronised reset, active high
  output logic      rst_o
);
  import ethrc_pkg::*;

  logic stage_q;

  ////////////////////////////////////////////////////////////////////////////
  // assert one cycle after the request, release two edges after it drops
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage_q <= 1'b1;
      rst_o   <= 1'b1;
    end else if (req_i) begin
      stage_q <= 1'b1;
      rst_o   <= 1'b1;
    end else begin
      stage_q <= 1'b0;
      rst_o   <= stage_q;
    end
  end

endmodule : ethrc_rst_sync

`default_nettype wire

// >>> ethrc_reset_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - power-on reset loads every register default; packet buffer content undefined.
// - power-on reset source is always active, no external pin needed.
// - system reset comes from the reset pin or a host reset command.
// - reset pin holds the device in reset while low, normal while high.
// - reset pin low pulses up to the qualification width are ignored.
// - internal resets never drive the external reset pin low.
// - system reset restores register defaults but keeps packet buffer contents.
// - system reset also performs transmit-only and receive-only resets.
// - transmit reset bit resets transmit logic; with a frame in flight, aborts it and clears transmit request.
// - transmit logic stays reset until host clears the bit; host side runs.
// - receive reset bit resets receive logic; clears receive enable, drops frame.
// - receive logic stays reset until host clears the bit; host side runs.
// - writing one to phy soft reset bit 15 restores all phy defaults.
// - phy soft reset bit clears itself after a delay; host polls it.
// - loopback bit 14 returns transmit data to receive, disables line.
// - power-down bit 11 shuts the phy down; clear means normal.
// - duplex bit 8 selects full duplex; reset value comes from strap.
module ethrc_reset_ctrl (
  // clock and power-on reset
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  // external reset pin and command
  input  wire logic        ext_reset_n_i,
  input  wire logic        sys_reset_cmd_i,
  // duplex strap from the led pin
  input  wire logic        duplex_strap_i,
  // register access port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_sel_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // transmit and receive engine status
  input  wire logic        tx_busy_i,
  input  wire logic        tx_done_i,
  input  wire logic        rx_busy_i,
  // reset outputs, active high
  output logic             sys_rst_o,
  output logic             tx_logic_rst_o,
  output logic             rx_logic_rst_o,
  output logic             phy_rst_o,
  // control and status outputs
  output logic             tx_request_o,
  output logic             rx_enable_o,
  output logic             tx_abort_o,
  output logic             rx_abort_o,
  output logic             phy_ready_o,
  output logic             phy_access_ok_o,
  output logic             phy_loopback_o,
  output logic             phy_power_down_o,
  output logic             phy_duplex_select_o,
  // mac side data path
  input  wire logic        mac_tx_en_i,
  input  wire logic [7:0]  mac_tx_data_i,
  output logic             mac_rx_en_o,
  output logic      [7:0]  mac_rx_data_o,
  // twisted-pair side data path
  input  wire logic        line_rx_en_i,
  input  wire logic [7:0]  line_rx_data_i,
  output logic             line_tx_en_o,
  output logic      [7:0]  line_tx_data_o,
  output logic             line_drv_en_o
);
  import ethrc_pkg::*;

  logic                 pin_qual;
  logic                 sys_req;
  logic                 tx_req;
  logic                 rx_req;
  logic                 phy_req;
  logic [7:0]           eth_ctrl_q;
  logic [7:0]           eth_ctrl_d;
  logic                 loopback_q;
  logic                 power_down_q;
  logic                 rsvd_hi_q;
  logic                 rsvd_lo_q;
  logic                 duplex_q;
  ethrc_phy_state_e     phy_state_q;
  logic [PHY_RST_W-1:0] phy_cnt_q;
  logic                 wr_eth;
  logic                 wr_phy;
  logic [15:0]          phy_ctrl_rd;
  logic                 tx_rst_bit_q;
  logic                 rx_rst_bit_q;
  logic [cnt_width(PHY_WAIT_CYC)-1:0] wait_cnt_q;

  //////////////////////////////////////////////////////////////////////////////
  // reset sources
  //////////////////////////////////////////////////////////////////////////////

  // arst_n_i is the always-on power-on reset; every flop takes a constant on it
  // the pin is only ever sampled here, no internal reset drives it back
  ethrc_rst_filter u_pin_filter (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .pin_n_i   (ext_reset_n_i),
    .qual_o    (pin_qual)
  );

  // either the qualified pin or the host command starts a system reset
  assign sys_req = pin_qual | sys_reset_cmd_i;

  // sync stages give a clean release to all downstream logic
  ethrc_rst_sync u_sys_sync (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .req_i     (sys_req),
    .rst_o     (sys_rst_o)
  );

  // transmit logic reset: system reset or the host control bit
  assign tx_req = sys_rst_o | eth_ctrl_q[ECTL_TX_RST];

  ethrc_rst_sync u_tx_sync (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .req_i     (tx_req),
    .rst_o     (tx_logic_rst_o)  // held until the bit is cleared
  );

  // receive logic reset: system reset or the host control bit
  assign rx_req = sys_rst_o | eth_ctrl_q[ECTL_RX_RST];

  ethrc_rst_sync u_rx_sync (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .req_i     (rx_req),
    .rst_o     (rx_logic_rst_o)  // held until the bit is cleared
  );

  // phy reset: system reset or the soft reset hold phase
  assign phy_req = sys_rst_o | (phy_state_q == PHY_HOLD);

  ethrc_rst_sync u_phy_sync (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .req_i     (phy_req),
    .rst_o     (phy_rst_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register access decode
  //////////////////////////////////////////////////////////////////////////////

  // the host port stays live during transmit or receive resets
  assign wr_eth = reg_wr_i & (reg_sel_i == REG_SEL_ETH_CTRL1);
  assign wr_phy = reg_wr_i & (reg_sel_i == REG_SEL_PHY_CTRL1);

  //////////////////////////////////////////////////////////////////////////////
  // ethernet_control_one
  //////////////////////////////////////////////////////////////////////////////

  // host write first; tx request clears only in cycles without a write, the receive enable clear always applies
  always_comb begin
    eth_ctrl_d = eth_ctrl_q;
    if (wr_eth) begin
      eth_ctrl_d = reg_wdata_i[7:0];
    end else begin
      if (tx_done_i) begin
        eth_ctrl_d[ECTL_TX_REQ] = 1'b0;
      end
      if (eth_ctrl_q[ECTL_TX_RST] && tx_busy_i) begin
        eth_ctrl_d[ECTL_TX_REQ] = 1'b0;  // frame aborted
      end
    end
    // receive enable cannot stay on while receive logic is reset
    if (eth_ctrl_d[ECTL_RX_RST]) begin
      eth_ctrl_d[ECTL_RX_EN] = 1'b0;
    end
  end

  // system reset returns the register to defaults; buffer memory is not ours
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eth_ctrl_q <= ECTL_RESET;
    end else if (sys_rst_o) begin
      eth_ctrl_q <= ECTL_RESET;
    end else begin
      eth_ctrl_q <= eth_ctrl_d;
    end
  end

  assign tx_request_o = eth_ctrl_q[ECTL_TX_REQ];
  assign rx_enable_o  = eth_ctrl_q[ECTL_RX_EN];

  //////////////////////////////////////////////////////////////////////////////
  // abort pulses
  //////////////////////////////////////////////////////////////////////////////

  // one-cycle abort when a reset bit rises while a frame is in flight
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_rst_bit_q <= 1'b0;
      rx_rst_bit_q <= 1'b0;
      tx_abort_o   <= 1'b0;
      rx_abort_o   <= 1'b0;
    end else begin
      tx_rst_bit_q <= eth_ctrl_q[ECTL_TX_RST];
      rx_rst_bit_q <= eth_ctrl_q[ECTL_RX_RST];
      tx_abort_o   <= eth_ctrl_q[ECTL_TX_RST] & ~tx_rst_bit_q & tx_busy_i;
      rx_abort_o   <= eth_ctrl_q[ECTL_RX_RST] & ~rx_rst_bit_q & rx_busy_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // phy soft reset sequencer
  //////////////////////////////////////////////////////////////////////////////

  // hold the phy for a fixed time, then reload the strap once reset lifts;
  // the strap is caught by a clocked step after release, never by the reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phy_state_q <= PHY_STRAP;
      phy_cnt_q   <= '0;
    end else if (sys_rst_o) begin
      phy_state_q <= PHY_STRAP;
      phy_cnt_q   <= '0;
    end else begin
      case (phy_state_q)
        PHY_IDLE: begin
          if (wr_phy && reg_wdata_i[PCTL_SOFT_RST]) begin
            phy_state_q <= PHY_HOLD;
            phy_cnt_q   <= PHY_RST_W'(PHY_RST_CYC - 1);
          end
        end
        PHY_HOLD: begin
          if (phy_cnt_q == '0) begin
            phy_state_q <= PHY_STRAP;
          end else begin
            phy_cnt_q <= phy_cnt_q - PHY_RST_W'(1);
          end
        end
        PHY_STRAP: begin
          if (!phy_rst_o) begin
            phy_state_q <= PHY_IDLE;  // soft reset bit drops here
          end
        end
        default: begin
          phy_state_q <= PHY_STRAP;
        end
      endcase
    end
  end

  assign phy_ready_o = (phy_state_q == PHY_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // phy_control_one fields
  //////////////////////////////////////////////////////////////////////////////

  // writes are ignored while the phy is busy resetting
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loopback_q   <= PCTL_RESET[PCTL_LOOPBACK];
      power_down_q <= PCTL_RESET[PCTL_PWR_DOWN];
      rsvd_hi_q    <= PCTL_RESET[PCTL_RSVD_HI];
      rsvd_lo_q    <= PCTL_RESET[PCTL_RSVD_LO];
      duplex_q     <= PCTL_RESET[PCTL_DUPLEX];
    end else if (phy_rst_o) begin
      loopback_q   <= PCTL_RESET[PCTL_LOOPBACK];
      power_down_q <= PCTL_RESET[PCTL_PWR_DOWN];
      rsvd_hi_q    <= PCTL_RESET[PCTL_RSVD_HI];
      rsvd_lo_q    <= PCTL_RESET[PCTL_RSVD_LO];
      duplex_q     <= PCTL_RESET[PCTL_DUPLEX];
    end else if (phy_state_q == PHY_STRAP) begin
      duplex_q     <= duplex_strap_i;
    end else if (wr_phy && phy_state_q == PHY_IDLE) begin
      loopback_q   <= reg_wdata_i[PCTL_LOOPBACK];
      power_down_q <= reg_wdata_i[PCTL_PWR_DOWN];
      rsvd_hi_q    <= reg_wdata_i[PCTL_RSVD_HI];  // host keeps zero
      rsvd_lo_q    <= reg_wdata_i[PCTL_RSVD_LO];
      duplex_q     <= reg_wdata_i[PCTL_DUPLEX];  // mac must match
    end
  end

  assign phy_loopback_o      = loopback_q;
  assign phy_power_down_o    = power_down_q;
  assign phy_duplex_select_o = duplex_q;

  //////////////////////////////////////////////////////////////////////////////
  // post-reset phy access window
  //////////////////////////////////////////////////////////////////////////////

  // status only: counts the wait after a system reset, the host still polls
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_cnt_q      <= '0;
      phy_access_ok_o <= 1'b0;
    end else if (sys_rst_o) begin
      wait_cnt_q      <= '0;
      phy_access_ok_o <= 1'b0;
    end else if (wait_cnt_q == ($bits(wait_cnt_q))'(PHY_WAIT_CYC)) begin
      phy_access_ok_o <= 1'b1;
    end else begin
      wait_cnt_q      <= wait_cnt_q + ($bits(wait_cnt_q))'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data path: loopback and power down
  //////////////////////////////////////////////////////////////////////////////

  // line driver is off in reset, power down and loopback
  assign line_drv_en_o = ~phy_rst_o & ~power_down_q & ~loopback_q;

  // registered mux; in loopback incoming line data is simply dropped
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mac_rx_en_o    <= 1'b0;
      mac_rx_data_o  <= 8'h00;
      line_tx_en_o   <= 1'b0;
      line_tx_data_o <= 8'h00;
    end else if (phy_rst_o || power_down_q) begin
      mac_rx_en_o    <= 1'b0;
      mac_rx_data_o  <= 8'h00;
      line_tx_en_o   <= 1'b0;
      line_tx_data_o <= 8'h00;
    end else if (loopback_q) begin
      mac_rx_en_o    <= mac_tx_en_i;
      mac_rx_data_o  <= mac_tx_data_i;
      line_tx_en_o   <= 1'b0;
      line_tx_data_o <= 8'h00;
    end else begin
      mac_rx_en_o    <= line_rx_en_i;
      mac_rx_data_o  <= line_rx_data_i;
      line_tx_en_o   <= mac_tx_en_i;
      line_tx_data_o <= mac_tx_data_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read back
  //////////////////////////////////////////////////////////////////////////////

  // soft reset bit reads one until the sequencer is back in idle
  always_comb begin
    phy_ctrl_rd                = 16'h0000;
    phy_ctrl_rd[PCTL_SOFT_RST] = (phy_state_q != PHY_IDLE);
    phy_ctrl_rd[PCTL_LOOPBACK] = loopback_q;
    phy_ctrl_rd[PCTL_PWR_DOWN] = power_down_q;
    phy_ctrl_rd[PCTL_RSVD_HI]  = rsvd_hi_q;
    phy_ctrl_rd[PCTL_DUPLEX]   = duplex_q;
    phy_ctrl_rd[PCTL_RSVD_LO]  = rsvd_lo_q;
  end

  // data is captured one cycle after the read strobe and held until the next
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (reg_sel_i == REG_SEL_ETH_CTRL1) begin
        reg_rdata_o <= {8'h00, eth_ctrl_q};
      end else begin
        reg_rdata_o <= phy_ctrl_rd & PCTL_IMPL;
      end
    end
  end

endmodule : ethrc_reset_ctrl

`default_nettype wire

// >>> ethrc_reset_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ethrc_reset_ctrl_sva (
  // clock, reset and stimulus
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic        ext_reset_n_i,
  input wire logic        sys_reset_cmd_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_sel_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        mac_tx_en_i,
  input wire logic [7:0]  mac_tx_data_i,
  // observed outputs
  input wire logic        sys_rst_o,
  input wire logic        tx_logic_rst_o,
  input wire logic        rx_logic_rst_o,
  input wire logic        phy_rst_o,
  input wire logic        tx_request_o,
  input wire logic        rx_enable_o,
  input wire logic        tx_abort_o,
  input wire logic        phy_ready_o,
  input wire logic        phy_loopback_o,
  input wire logic        phy_power_down_o,
  input wire logic        mac_rx_en_o,
  input wire logic [7:0]  mac_rx_data_o,
  input wire logic        line_tx_en_o,
  input wire logic        line_drv_en_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  logic [4:0] low_q;
  // consecutive low samples of the pin, saturating so long holds never wrap
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) low_q <= 5'h00;
    else if (ext_reset_n_i) low_q <= 5'h00;
    else if (low_q != 5'h1f) low_q <= low_q + 5'h01;
  end
  sequence s_phy_soft_reset_req;
    reg_wr_i && reg_sel_i && reg_wdata_i[15] && phy_ready_o && !sys_rst_o;
  endsequence
  sequence s_phy_soft_reset_run;
    ##[1:3] phy_rst_o[*8] ##[200:300] !phy_rst_o;
  endsequence
  property p_cmd;  sys_reset_cmd_i |=> sys_rst_o; endproperty
  property p_pin;  low_q >= 5'h0e |-> sys_rst_o; endproperty
  property p_glitch; $rose(sys_rst_o) |-> low_q >= 5'h0a || $past(sys_reset_cmd_i); endproperty
  property p_sys_all; sys_rst_o |-> ##[0:3] (tx_logic_rst_o && rx_logic_rst_o); endproperty
  property p_abort; tx_abort_o |-> !tx_request_o ##1 !tx_abort_o; endproperty
  property p_rx; $rose(rx_logic_rst_o) |-> !rx_enable_o; endproperty
  property p_loop; phy_loopback_o |-> !line_drv_en_o ##1 !line_tx_en_o; endproperty
  property p_loopdata;
    phy_loopback_o && !phy_power_down_o && !phy_rst_o && mac_tx_en_i
      |=> mac_rx_en_o && mac_rx_data_o == $past(mac_tx_data_i);
  endproperty
  property p_pwr; phy_power_down_o |=> !line_tx_en_o && !mac_rx_en_o; endproperty
  property p_phy_hold; s_phy_soft_reset_req |-> s_phy_soft_reset_run; endproperty
  property p_ready; phy_rst_o |-> !phy_ready_o; endproperty
  a_cmd: assert property (p_cmd) else $error("command did not start reset");
  a_pin: assert property (p_pin) else $error("long pin low not in reset");
  a_glitch: assert property (p_glitch) else $error("reset without cause");
  a_sys_all: assert property (p_sys_all) else $error("tx or rx reset missing");
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  a_rx: assert property (p_rx) else $error("rx enable kept in reset");
  a_loop: assert property (p_loop) else $error("driver on in loopback");
  a_loopdata: assert property (p_loopdata) else $error("loopback data wrong");
  a_pwr: assert property (p_pwr) else $error("data moves in power down");
  a_phy_hold: assert property (p_phy_hold) else $error("phy reset span wrong");
  a_ready: assert property (p_ready) else $error("ready during phy reset");
endmodule : ethrc_reset_ctrl_sva
bind ethrc_reset_ctrl ethrc_reset_ctrl_sva i_ethrc_reset_ctrl_sva (.*);
`default_nettype wire

// >>> ethrc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ethrc_host_model (
  // clock
  input  wire logic        clk_sys_i,
  // register port toward the device
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic             reg_sel_o,
  output logic      [15:0] reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        phy_access_ok_i
);
  import ethrc_pkg::*;
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_sel_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end
  // phy access waits out the settle time after any system reset
  task automatic gate(input logic sel);
    int n;
    n = 0;
    while (sel == REG_SEL_PHY_CTRL1 && phy_access_ok_i !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask : gate
  // reserved phy bits always go out as zero
  task automatic wr(input logic sel, input logic [15:0] d);
    gate(sel);
    @(posedge clk_sys_i);
    #1 reg_wr_o = 1'b1;
    reg_sel_o = sel;
    reg_wdata_o = sel ? (d & 16'hfb7f) : d;
    @(posedge clk_sys_i);
    #1 reg_wr_o = 1'b0;
    reg_wdata_o = ~reg_wdata_o;
  endtask : wr
  task automatic rd(input logic sel, output logic [15:0] d);
    gate(sel);
    @(posedge clk_sys_i);
    #1 reg_rd_o = 1'b1;
    reg_sel_o = sel;
    @(posedge clk_sys_i);
    #1 reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask : rd
  // poll the self-clearing soft reset bit before using the phy again
  task automatic poll(output logic ok);
    logic [15:0] d;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      rd(1'b1, d);
      ok = (d[15] === 1'b0);
    end
  endtask : poll
endmodule : ethrc_host_model
`default_nettype wire

// >>> ethrc_reset_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module ethrc_reset_ctrl_test;
  logic clk = 1'b0, arst_n = 1'b0, ext_n = 1'b1, cmd = 1'b0, strap = 1'b1;
  logic wr, rd, sel, txb = 1'b0, rxb = 1'b0, mte = 1'b0, lre = 1'b0, ok;
  logic sr, txr, rxr, pr, treq, ren, tab, rab, prdy, pok, lb, pd, dx, mre, lte, drv;
  logic [15:0] wd, rdat, d;
  logic [7:0] mtd = 8'h00, lrd = 8'h00, mrd, ltd;
  logic seen_ta = 1'b0, seen_ra = 1'b0, seen_sr = 1'b0;
  int fail_count = 0, checks_done = 0;
  initial forever #20 clk = ~clk;
  ethrc_reset_ctrl i_ethrc_reset_ctrl (.clk_sys_i(clk), .arst_n_i(arst_n),
    .ext_reset_n_i(ext_n), .sys_reset_cmd_i(cmd), .duplex_strap_i(strap), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_sel_i(sel), .reg_wdata_i(wd), .reg_rdata_o(rdat), .tx_busy_i(txb),
    .tx_done_i(1'b0), .rx_busy_i(rxb), .sys_rst_o(sr), .tx_logic_rst_o(txr),
    .rx_logic_rst_o(rxr), .phy_rst_o(pr), .tx_request_o(treq), .rx_enable_o(ren),
    .tx_abort_o(tab), .rx_abort_o(rab), .phy_ready_o(prdy), .phy_access_ok_o(pok),
    .phy_loopback_o(lb), .phy_power_down_o(pd), .phy_duplex_select_o(dx),
    .mac_tx_en_i(mte), .mac_tx_data_i(mtd), .mac_rx_en_o(mre), .mac_rx_data_o(mrd),
    .line_rx_en_i(lre), .line_rx_data_i(lrd), .line_tx_en_o(lte), .line_tx_data_o(ltd),
    .line_drv_en_o(drv));
  ethrc_host_model h (.clk_sys_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_sel_o(sel),
    .reg_wdata_o(wd), .reg_rdata_i(rdat), .phy_access_ok_i(pok));
  // latch one-cycle pulses so a check later on cannot miss them
  always @(posedge clk) begin
    if (tab === 1'b1) seen_ta = 1'b1;
    if (rab === 1'b1) seen_ra = 1'b1;
    if (sr === 1'b1) seen_sr = 1'b1;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // one beat on both data inputs, then the registered outputs
  task automatic dp(input string n, input logic [18:0] e);
    @(posedge clk);
    #1 {mte, mtd, lre, lrd} = {1'b1, 8'h3c, 1'b1, 8'h5a};
    @(posedge clk);
    #1 chk(n, e, {mre, mrd, lte, ltd, drv});
    {mte, lre} = 2'b00;
  endtask : dp
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  initial begin
    cyc(20);
    arst_n = 1'b1;
    cyc(5);
    h.rd(0, d); chk("ectl default", 16'h0000, d);
    chk("access wait", 1'b0, pok);
    h.rd(1, d); chk("pctl default", 16'h0100, d);
    chk("access ok", 1'b1, pok);
    h.wr(1, 16'h7fff); h.rd(1, d); chk("pctl mask", 16'h4900, d);
    chk("phy bits", 3'b111, {lb, pd, dx});
    $display("test registers done");
    h.wr(1, 16'h0100); dp("normal", {1'b1, 8'h5a, 1'b1, 8'h3c, 1'b1});
    h.wr(1, 16'h4100); dp("loopback", {1'b1, 8'h3c, 1'b0, 8'h00, 1'b0});
    h.wr(1, 16'h0900); dp("power down", 19'h00000);
    $display("test data path done");
    strap = 1'b0;
    h.wr(1, 16'h8000); h.rd(1, d); chk("soft reset bit", 1'b1, d[15]);
    h.poll(ok); chk("soft reset clears", 1'b1, ok);
    h.rd(1, d); chk("pctl after soft", 16'h0000, d);
    $display("test phy reset done");
    txb = 1'b1;
    h.wr(0, 16'h0008); chk("tx request", 1'b1, treq);
    h.wr(0, 16'h0088); cyc(2); chk("tx reset", 3'b101, {txr, treq, seen_ta});
    h.rd(0, d); chk("ectl in tx reset", 16'h0080, d);
    h.wr(0, 16'h0000); txb = 1'b0; cyc(3); chk("tx reset off", 1'b0, txr);
    rxb = 1'b1;
    h.wr(0, 16'h0004); h.wr(0, 16'h0044); cyc(2);
    chk("rx reset", 3'b101, {rxr, ren, seen_ra});
    h.rd(0, d); chk("ectl in rx reset", 16'h0040, d);
    h.wr(0, 16'h0000); rxb = 1'b0; cyc(3); chk("rx reset off", 1'b0, rxr);
    $display("test tx rx reset done");
    h.wr(0, 16'h0004); seen_sr = 1'b0;
    ext_n = 1'b0; cyc(10); ext_n = 1'b1; cyc(5); chk("glitch ignored", 1'b0, seen_sr);
    ext_n = 1'b0; cyc(20); chk("pin reset", 1'b1, sr);
    ext_n = 1'b1; cyc(6); chk("pin release", 1'b0, sr);
    h.rd(0, d); chk("ectl after pin", 16'h0000, d);
    h.wr(0, 16'h0084); cmd = 1'b1; cyc(1); cmd = 1'b0; cyc(1);
    chk("cmd reset", 3'b111, {sr, txr, rxr});
    cyc(2); seen_sr = 1'b0; cyc(14); chk("pin not driven", 1'b0, seen_sr);
    h.rd(0, d); chk("ectl after cmd", 16'h0000, d);
    $display("test system reset done");
    report_and_stop();
  end
  // hang guard, about twelve times the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule : ethrc_reset_ctrl_test
`default_nettype wire
